// ==== tb_uis_status.sv ====
// Self-checking testbench of the USB status block.
`timescale 1ns/1ps
module tb_uis_status;
	import uis_pkg::*;
	logic        mclk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	uis_req_t    req = '0;
	uis_evt_t    evt = '0;
	uis_line_t   line;
	uis_line_t   st = UIS_LINE_J;
	logic [31:0] rdata;
	logic [31:0] d;
	logic [31:0] seed = 32'h4c57ba2f;
	logic [11:0] len = 12'h0;
	logic [7:0]  a;
	logic        lbusy = 1'b0;
	logic        go = 1'b0;
	logic        irq;
	logic        mbusy;
	logic        hen;
	logic        adv;
	int          adv_cnt = 0;
	int          err_total = 0;
	int          comparisons = 0;
	// Columns: event bit, register offset, flag bit, host mode.
	logic [7:0]  tbl [13][4] = '{'{14,0,7,1}, '{13,0,7,0}, '{12,0,3,0}, '{11,0,2,0},
		'{10,0,2,1}, '{9,8,7,0}, '{8,8,6,0}, '{7,8,5,0}, '{6,8,3,0}, '{5,8,2,0},
		'{4,8,1,0}, '{3,8,1,1}, '{2,8,0,0}};
	always #2 mclk_i = ~mclk_i;
	// Counting advance pulses catches a missing one as well as a doubled one.
	always @(posedge mclk_i)
		if (adv === 1'b1)
			adv_cnt++;
	uis_status #(.IDLE_CYCLES(1000)) dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.reg_req_i(req), .reg_rdata_o(rdata), .line_state_i(line), .evt_i(evt),
		.link_busy_i(lbusy), .host_operation_enable_o(hen), .token_fifo_advance_o(adv),
		.module_interrupt_request_o(irq));
	uis_bus_model bus_u (.mclk_i(mclk_i), .go_i(go), .state_i(st), .len_i(len),
		.line_state_o(line), .busy_o(mbusy));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic print_verdict(input logic t);
		if (t)
			err_total++;
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] v);
		req <= '{ad, v, 1'b1, 1'b0};
		@(posedge mclk_i);
		req <= '0;
		@(posedge mclk_i);
	endtask
	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [7:0] ad);
		req <= '{ad, 32'h0, 1'b0, 1'b1};
		@(posedge mclk_i);
		req <= '0;
		#1 d = rdata;
		@(posedge mclk_i);
	endtask
	task automatic pulse(input int b);
		evt <= uis_evt_t'(15'h1 << b);
		@(posedge mclk_i);
		evt <= '0;
		@(posedge mclk_i);
	endtask
	task automatic hold(input uis_line_t s, input logic [11:0] n);
		int i;
		st <= s;
		len <= n;
		go <= 1'b1;
		@(posedge mclk_i);
		go <= 1'b0;
		for (i = 0; i < 3000 && (i == 0 || mbusy); i++)
			@(negedge mclk_i);
		if (mbusy)
			print_verdict(1'b1);
		@(posedge mclk_i);
	endtask
	initial
	begin
		repeat (20) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		@(posedge mclk_i);
		for (int k = 0; k < 24; k += 4)
		begin
			rd(8'(k));
			chk("reset_value", 32'h0, d);
		end
		for (int k = 0; k < 6; k++)
		begin
			seed = lfsr(seed);
			a = k[0] ? 8'h0c : 8'h04;
			wr(a, seed);
			rd(a);
			chk("enable_readback", {24'h0, seed[7:0]}, d);
		end
		wr(8'h14, seed);
		rd(8'h14);
		chk("unmapped", 32'h0, d);
		wr(8'h04, 32'h0);
		wr(8'h0c, 32'h0);
		$display("Test registers done");
		lbusy <= 1'b1;
		foreach (tbl[i])
		begin
			wr(8'h10, {24'h0, tbl[i][3]});
			chk("host_enable", {24'h0, tbl[i][3]}, {31'h0, hen});
			pulse(tbl[i][0]);
			rd(tbl[i][1]);
			chk("flag_set", 32'h1, d[tbl[i][2]]);
			wr(tbl[i][1], ~(32'h1 << tbl[i][2]));
			rd(tbl[i][1]);
			chk("flag_kept", 32'h1, d[tbl[i][2]]);
			wr(tbl[i][1], 32'h1 << tbl[i][2]);
			rd(tbl[i][1]);
			chk("flag_clear", 32'h0, d[tbl[i][2]]);
			chk("irq_masked", 32'h0, irq);
		end
		lbusy <= 1'b0;
		chk("fifo_advance", 32'h1, adv_cnt);
		wr(8'h10, 32'h1);
		pulse(3);
		rd(8'h08);
		chk("eof_quiet_link", 32'h0, d[1]);
		$display("Test flags done");
		wr(8'h04, 32'h2);
		wr(8'h08, 32'hff);
		pulse(5);
		rd(8'h00);
		chk("summary_masked", 32'h0, d[1]);
		chk("irq_err_masked", 32'h0, irq);
		wr(8'h0c, 32'h4);
		wr(8'h00, 32'h2);
		rd(8'h00);
		chk("summary_set", 32'h1, d[1]);
		chk("irq_err", 32'h1, irq);
		wr(8'h08, 32'h4);
		rd(8'h00);
		chk("summary_clear", 32'h0, d[1]);
		chk("irq_clear", 32'h0, irq);
		for (int k = 0; k < 8; k++)
		begin
			seed = lfsr(seed);
			wr(8'h04, {24'h0, seed[7:0] & 8'hcd});
			wr(8'h00, 32'hff);
			pulse(12);
			repeat (2) @(negedge mclk_i);
			chk("irq_token", {31'h0, seed[3]}, irq);
			@(posedge mclk_i);
		end
		wr(8'h04, 32'h0);
		$display("Test interrupt done");
		wr(8'h10, 32'h0);
		hold(UIS_LINE_K, 12'h270);
		rd(8'h00);
		chk("resume_short", 32'h0, d[5]);
		hold(UIS_LINE_K, 12'h2bc);
		rd(8'h00);
		chk("resume_long", 32'h1, d[5]);
		hold(UIS_LINE_SE0, 12'h2bc);
		rd(8'h00);
		chk("bus_reset", 32'h1, d[0]);
		wr(8'h10, 32'h1);
		wr(8'h00, 32'hff);
		hold(UIS_LINE_J, 12'h2bc);
		rd(8'h00);
		chk("attach", 32'h1, d[6]);
		hold(UIS_LINE_SE0, 12'h2bc);
		rd(8'h00);
		chk("detach", 32'h1, d[0]);
		hold(UIS_LINE_J, 12'h44c);
		rd(8'h00);
		chk("idle", 32'h1, d[4]);
		wr(8'h08, 32'hff);
		pulse(1);
		pulse(0);
		hold(UIS_LINE_J, 12'h190);
		rd(8'h08);
		chk("turn_answered", 32'h0, d[4]);
		pulse(1);
		hold(UIS_LINE_J, 12'h190);
		rd(8'h08);
		chk("turn_timeout", 32'h1, d[4]);
		$display("Test line done");
		print_verdict(1'b0);
	end
endmodule // tb_uis_status

// ==== uis_bus_model.sv ====
// Bus partner model that holds one line state for a commanded number of cycles.
`timescale 1ns/1ps
module uis_bus_model
	import uis_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        go_i,
	input  wire uis_line_t   state_i,
	input  wire logic [11:0] len_i,
	output uis_line_t        line_state_o,
	output logic             busy_o
);
	logic [11:0] cnt_reg = 12'h0;
	initial line_state_o = UIS_LINE_J;
	assign busy_o = (cnt_reg != 12'h0);
	// held line
	// The released bus is pulled to J, so every hold of nonzero length ends in Idle.
	always @(posedge mclk_i)
	begin
		if (go_i)
		begin
			line_state_o <= state_i;
			cnt_reg <= len_i;
		end
		else if (busy_o)
		begin
			cnt_reg <= cnt_reg - 12'h1;
			if (cnt_reg == 12'h1)
				line_state_o <= UIS_LINE_J;
		end
	end
endmodule // uis_bus_model

// ==== uis_consts.svh ====
// Register offsets, field positions, reset values and timing counts of the USB status block.
`ifndef UIS_CONSTS_SVH
`define UIS_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define UIS_OFS_EVENT_FLAGS   8'h00
`define UIS_OFS_EVENT_ENABLES 8'h04
`define UIS_OFS_ERROR_FLAGS   8'h08
`define UIS_OFS_ERROR_ENABLES 8'h0c
`define UIS_OFS_CONTROL       8'h10

// ==========================================================================
// Field positions
`define UIS_EVT_BUS_RESET     0
`define UIS_EVT_ERR_SUMMARY   1
`define UIS_EVT_FRAME_START   2
`define UIS_EVT_TOKEN_DONE    3
`define UIS_EVT_IDLE          4
`define UIS_EVT_RESUME        5
`define UIS_EVT_ATTACH        6
`define UIS_EVT_STALL         7
`define UIS_ERR_PACKET_ID     0
`define UIS_ERR_TOKEN_CRC     1
`define UIS_ERR_DATA_CRC      2
`define UIS_ERR_PARTIAL_BYTE  3
`define UIS_ERR_TURNAROUND    4
`define UIS_ERR_MEM_ACCESS    5
`define UIS_ERR_BUS_MATRIX    6
`define UIS_ERR_BIT_STUFF     7
`define UIS_CTL_HOST_EN       0

// ==========================================================================
// Reset values
`define UIS_RST_FLAGS         8'h00
`define UIS_RST_ENABLES       8'h00
`define UIS_RST_CONTROL       8'h00

// ==========================================================================
// Timing
`define UIS_CLK_PERIOD_NS     4
`define UIS_CLK_MHZ           250
`define UIS_BIT_RATE_MHZ      12
`define UIS_LINE_TIME_NS      2500
`define UIS_IDLE_TIME_US      3000
`define UIS_TURNAROUND_BITS   16
`define UIS_LINE_CYCLES ((`UIS_LINE_TIME_NS + `UIS_CLK_PERIOD_NS - 1) / `UIS_CLK_PERIOD_NS)
`define UIS_IDLE_CYCLES ((`UIS_IDLE_TIME_US * 1000 + `UIS_CLK_PERIOD_NS - 1) / `UIS_CLK_PERIOD_NS)
`define UIS_TURN_CYCLES ((`UIS_TURNAROUND_BITS * `UIS_CLK_MHZ) / `UIS_BIT_RATE_MHZ + 1)

`endif

// ==== uis_pkg.sv ====
// Types shared by the USB status block and its environment.
package uis_pkg;

	// ======================================================================
	// Bus line state
	typedef enum logic [1:0]
	{
		UIS_LINE_SE0 = 2'h0,
		UIS_LINE_J   = 2'h1,
		UIS_LINE_K   = 2'h2,
		UIS_LINE_SE1 = 2'h3
	} uis_line_t;

	// ======================================================================
	// One-cycle event pulses from the packet engine
	typedef struct packed
	{
		logic stall_rx;
		logic stall_tx;
		logic token_done;
		logic sof_rx;
		logic sof_threshold;
		logic bit_stuff_err;
		logic bus_matrix_err;
		logic mem_access_err;
		logic partial_byte_err;
		logic data_crc_err;
		logic token_crc_err;
		logic sof_count_zero;
		logic packet_id_err;
		logic eop;
		logic response_start;
	} uis_evt_t;

	// ======================================================================
	// Register port
	typedef struct packed
	{
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} uis_req_t;

endpackage

// ==== uis_status.sv ====
// Interrupt and error status logic of a full-speed USB controller.
// Contract
// - Stall flag: host on received STALL, device on transmitted STALL.
// - Attach flag in host mode after 2.5 us quiet non-SE0 bus.
// - Resume flag when K state persists 2.5 us.
// - Idle flag after 3 ms continuous Idle.
// - Token-done flag when token processing finishes; status shows endpoint.
// - Clearing token-done flag advances the transfer status FIFO.
// - Frame-start flag on SOF received (device) or threshold (host).
// - Error summary is read-only, set only by enabled active errors.
// - Bit 0 flags valid bus reset in device mode.
// - Bit 0 flags peripheral detach in host mode.
// - Flags hardware-set, zero at reset, write one clears.
// - Enable bits read/write, reset zero, gate same-position flag.
// - Errors reach interrupt only through the error summary enable.
// - Bit-stuff error flag on stuffing violation.
// - Bus matrix error flag on invalid descriptor or buffer address.
// - Memory access error flag on late grant or truncated packet.
// - Turnaround timeout after more than 16 bit-times of Idle.
// - Partial byte error when data field is not whole bytes.
// - Data CRC error flag on CRC16 failure.
// - Host: error bit 1 on busy when SOF counter reaches zero.
// - Bits 31 to 8 of every register read zero.
// - Device: error bit 1 on token CRC5 failure.
// - Error bit 0 on packet identifier check failure.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "uis_consts.svh"

module uis_status
	import uis_pkg::*;
#(
	parameter int unsigned IDLE_CYCLES = `UIS_IDLE_CYCLES
)
(
	input  wire logic        mclk_i,
	input  wire logic        sys_rst_i,
	input  wire uis_req_t    reg_req_i,
	output logic      [31:0] reg_rdata_o,
	input  wire uis_line_t   line_state_i,
	input  wire uis_evt_t    evt_i,
	input  wire logic        link_busy_i,
	output logic             host_operation_enable_o,
	output logic             token_fifo_advance_o,
	output logic             module_interrupt_request_o
);

	// ======================================================================
	// Constants and helpers
	localparam logic [19:0] LINE_CYC = 20'(`UIS_LINE_CYCLES);
	localparam logic [19:0] IDLE_CYC = 20'(IDLE_CYCLES);
	localparam logic [8:0]  TURN_CYC = 9'(`UIS_TURN_CYCLES);

	function automatic logic hit(input logic [7:0] ofs);
		hit = reg_req_i.addr == ofs;
	endfunction

	// Set wins over clear so an event in the clearing cycle is kept.
	function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
	                                   input logic clr_en, input logic [7:0] clr);
		w1c = (cur & ~(clr_en ? clr : 8'h00)) | set;
	endfunction

	// ======================================================================
	// Registers
	logic [7:0]  evt_flags_reg;
	logic [7:0]  evt_flags_next;
	logic [7:0]  evt_en_reg;
	logic [7:0]  evt_en_next;
	logic [7:0]  err_flags_reg;
	logic [7:0]  err_flags_next;
	logic [7:0]  err_en_reg;
	logic [7:0]  err_en_next;
	logic [7:0]  ctl_reg;
	logic [7:0]  ctl_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        adv_reg;
	logic        adv_next;
	logic        irq_reg;
	logic        irq_next;

	// ======================================================================
	// Line monitor state
	uis_line_t   prev_line_reg;
	uis_line_t   prev_line_next;
	logic [19:0] stable_reg;
	logic [19:0] stable_next;
	logic        detached_reg;
	logic        detached_next;
	logic        turn_arm_reg;
	logic        turn_arm_next;
	logic [8:0]  turn_cnt_reg;
	logic [8:0]  turn_cnt_next;

	logic        host_mode;
	logic        line_timed;
	logic        idle_timed;
	logic        turn_timeout;
	logic        error_summary_flag;
	logic [7:0]  evt_set;
	logic [7:0]  err_set;
	logic [7:0]  evt_view;

	assign host_mode = ctl_reg[`UIS_CTL_HOST_EN];

	// ======================================================================
	// Line timing
	always_comb
	begin
		prev_line_next = line_state_i;
		if (line_state_i != prev_line_reg)
			stable_next = 20'h00001;
		else if (stable_reg != 20'hfffff)
			stable_next = stable_reg + 20'h00001;
		else
			stable_next = stable_reg;
		line_timed = (line_state_i == prev_line_reg) && (stable_reg == LINE_CYC - 20'h00001);
		idle_timed = (line_state_i == UIS_LINE_J) && (line_state_i == prev_line_reg)
		             && (stable_reg == IDLE_CYC - 20'h00001);
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			prev_line_reg <= UIS_LINE_SE0;
			stable_reg    <= 20'h00000;
		end
		else
		begin
			prev_line_reg <= prev_line_next;
			stable_reg    <= stable_next;
		end
	end

	// ======================================================================
	// Attach tracking
	// Starting out detached lets a host that sets host mode within 2.5 us of reset release report a peripheral already present at reset.
	always_comb
	begin
		detached_next = detached_reg;
		if (line_timed && line_state_i == UIS_LINE_SE0)
			detached_next = 1'b1;
		else if (line_timed && line_state_i != UIS_LINE_SE0)
			detached_next = 1'b0;
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			detached_reg <= 1'b1;
		else
			detached_reg <= detached_next;
	end

	// ======================================================================
	// Turnaround timer
	// Any non-Idle line state disarms the timer, so an answer that comes before the limit is never a timeout.
	always_comb
	begin
		turn_arm_next = turn_arm_reg;
		turn_cnt_next = turn_cnt_reg;
		turn_timeout  = 1'b0;
		if (evt_i.eop)
		begin
			turn_arm_next = 1'b1;
			turn_cnt_next = 9'h000;
		end
		else if (turn_arm_reg)
		begin
			if (evt_i.response_start || line_state_i != UIS_LINE_J)
				turn_arm_next = 1'b0;
			else if (turn_cnt_reg == TURN_CYC - 9'h001)
			begin
				turn_timeout  = 1'b1;
				turn_arm_next = 1'b0;
			end
			else
				turn_cnt_next = turn_cnt_reg + 9'h001;
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			turn_arm_reg <= 1'b0;
			turn_cnt_reg <= 9'h000;
		end
		else
		begin
			turn_arm_reg <= turn_arm_next;
			turn_cnt_reg <= turn_cnt_next;
		end
	end

	// ======================================================================
	// Event sources
	always_comb
	begin
		evt_set = 8'h00;
		err_set = 8'h00;
		evt_set[`UIS_EVT_STALL] = host_mode ? evt_i.stall_rx : evt_i.stall_tx;
		evt_set[`UIS_EVT_ATTACH] = host_mode && detached_reg && line_timed
		                           && line_state_i != UIS_LINE_SE0;
		evt_set[`UIS_EVT_RESUME] = line_timed && line_state_i == UIS_LINE_K;
		evt_set[`UIS_EVT_IDLE] = idle_timed;
		evt_set[`UIS_EVT_TOKEN_DONE] = evt_i.token_done;
		evt_set[`UIS_EVT_FRAME_START] = host_mode ? evt_i.sof_threshold : evt_i.sof_rx;
		evt_set[`UIS_EVT_BUS_RESET] = line_timed && line_state_i == UIS_LINE_SE0
		                              && (host_mode ? !detached_reg : 1'b1);
		err_set[`UIS_ERR_BIT_STUFF] = evt_i.bit_stuff_err;
		err_set[`UIS_ERR_BUS_MATRIX] = evt_i.bus_matrix_err;
		err_set[`UIS_ERR_MEM_ACCESS] = evt_i.mem_access_err;
		err_set[`UIS_ERR_TURNAROUND] = turn_timeout;
		err_set[`UIS_ERR_PARTIAL_BYTE] = evt_i.partial_byte_err;
		err_set[`UIS_ERR_DATA_CRC] = evt_i.data_crc_err;
		err_set[`UIS_ERR_TOKEN_CRC] = host_mode ? (evt_i.sof_count_zero && link_busy_i)
		                                        : evt_i.token_crc_err;
		err_set[`UIS_ERR_PACKET_ID] = evt_i.packet_id_err;
	end

	// ======================================================================
	// Register file
	always_comb
	begin
		evt_flags_next = w1c(evt_flags_reg, evt_set,
		                     reg_req_i.wr && hit(`UIS_OFS_EVENT_FLAGS), reg_req_i.wdata[7:0]);
		evt_flags_next[`UIS_EVT_ERR_SUMMARY] = 1'b0;
		err_flags_next = w1c(err_flags_reg, err_set,
		                     reg_req_i.wr && hit(`UIS_OFS_ERROR_FLAGS), reg_req_i.wdata[7:0]);
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			evt_flags_reg <= `UIS_RST_FLAGS;
			err_flags_reg <= `UIS_RST_FLAGS;
		end
		else
		begin
			evt_flags_reg <= evt_flags_next;
			err_flags_reg <= err_flags_next;
		end
	end

	// ======================================================================
	// Enables and control
	always_comb
	begin
		evt_en_next = (reg_req_i.wr && hit(`UIS_OFS_EVENT_ENABLES))
		              ? reg_req_i.wdata[7:0] : evt_en_reg;
		err_en_next = (reg_req_i.wr && hit(`UIS_OFS_ERROR_ENABLES))
		              ? reg_req_i.wdata[7:0] : err_en_reg;
		ctl_next = (reg_req_i.wr && hit(`UIS_OFS_CONTROL))
		           ? {7'h00, reg_req_i.wdata[`UIS_CTL_HOST_EN]} : ctl_reg;
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			evt_en_reg <= `UIS_RST_ENABLES;
			err_en_reg <= `UIS_RST_ENABLES;
			ctl_reg    <= `UIS_RST_CONTROL;
		end
		else
		begin
			evt_en_reg <= evt_en_next;
			err_en_reg <= err_en_next;
			ctl_reg    <= ctl_next;
		end
	end

	// ======================================================================
	// Transfer status advance
	always_comb
	begin
		adv_next = reg_req_i.wr && hit(`UIS_OFS_EVENT_FLAGS)
		           && reg_req_i.wdata[`UIS_EVT_TOKEN_DONE] && evt_flags_reg[`UIS_EVT_TOKEN_DONE];
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			adv_reg <= 1'b0;
		else
			adv_reg <= adv_next;
	end

	// ======================================================================
	// Read port
	// Read data drop back to zero outside the read slot, so no stale value lingers.
	always_comb
	begin
		rdata_next = 32'h00000000;
		if (reg_req_i.rd)
		begin
			unique case (reg_req_i.addr)
				`UIS_OFS_EVENT_FLAGS:   rdata_next[7:0] = evt_view;
				`UIS_OFS_EVENT_ENABLES: rdata_next[7:0] = evt_en_reg;
				`UIS_OFS_ERROR_FLAGS:   rdata_next[7:0] = err_flags_reg;
				`UIS_OFS_ERROR_ENABLES: rdata_next[7:0] = err_en_reg;
				`UIS_OFS_CONTROL:       rdata_next[7:0] = ctl_reg;
				default:                rdata_next      = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			rdata_reg <= 32'h00000000;
		else
			rdata_reg <= rdata_next;
	end

	// ======================================================================
	// Interrupt request
	// masked errors never raise the summary
	assign error_summary_flag = |(err_flags_reg & err_en_reg);

	always_comb
	begin
		evt_view = evt_flags_reg;
		evt_view[`UIS_EVT_ERR_SUMMARY] = error_summary_flag;
		irq_next = |(evt_view & evt_en_reg);
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			irq_reg <= 1'b0;
		end
		else
		begin
			irq_reg <= irq_next;
		end
	end

	// The request lags the flags by one cycle, which keeps the output glitch-free.
	assign reg_rdata_o                = rdata_reg;
	assign host_operation_enable_o    = host_mode;
	assign token_fifo_advance_o       = adv_reg;
	assign module_interrupt_request_o = irq_reg;

endmodule // uis_status

// ==== uis_status_chk.sv ====
// Assertion checker for the USB status block.
`timescale 1ns/1ps
module uis_status_chk
	import uis_pkg::*;
#(
	parameter int unsigned IDLE_CYCLES = 1000
)
(
	input wire logic        mclk_i,
	input wire logic        sys_rst_i,
	input wire uis_req_t    reg_req_i,
	input wire logic [31:0] reg_rdata_o,
	input wire uis_line_t   line_state_i,
	input wire uis_evt_t    evt_i,
	input wire logic        link_busy_i,
	input wire logic        host_operation_enable_o,
	input wire logic        token_fifo_advance_o,
	input wire logic        module_interrupt_request_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_rd(logic [7:0] a);
		reg_req_i.rd && reg_req_i.addr == a;
	endsequence
	// A flag set by a pulse must show on a read two cycles later with no clear between.
	property p_seen(logic ev, logic [7:0] a, int b);
		ev ##1 !reg_req_i.wr ##1 s_rd(a) |=> reg_rdata_o[b];
	endproperty
	// ======================================================================
	// Read port
	a_rdata_quiet: assert property (!$past(reg_req_i.rd) |-> reg_rdata_o == 32'h0)
		else $error("read data not zero outside read slot");
	a_upper_zero: assert property (reg_rdata_o[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_ctrl_read: assert property (s_rd(8'h10) |=> reg_rdata_o == {31'h0, host_operation_enable_o})
		else $error("control read differs from host enable");
	// ======================================================================
	// Side effects and interrupt
	a_advance_cause: assert property (token_fifo_advance_o |->
		$past(reg_req_i.wr && reg_req_i.addr == 8'h00 && reg_req_i.wdata[3]))
		else $error("fifo advance without token flag clear");
	a_irq_fall: assert property ($fell(module_interrupt_request_o) |->
		$past(reg_req_i.wr) || $past(reg_req_i.wr, 2))
		else $error("interrupt dropped without a write");
	// ======================================================================
	// Flag setting
	a_token_seen: assert property (p_seen(evt_i.token_done, 8'h00, 3))
		else $error("token flag missing");
	a_stuff_seen: assert property (p_seen(evt_i.bit_stuff_err, 8'h08, 7))
		else $error("bit stuff flag missing");
	a_crc_seen: assert property (p_seen(evt_i.data_crc_err, 8'h08, 2))
		else $error("data crc flag missing");
	a_pid_seen: assert property (p_seen(evt_i.packet_id_err, 8'h08, 0))
		else $error("packet id flag missing");
endmodule // uis_status_chk

bind uis_status uis_status_chk #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (.mclk_i(mclk_i),
	.sys_rst_i(sys_rst_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
	.line_state_i(line_state_i), .evt_i(evt_i), .link_busy_i(link_busy_i),
	.host_operation_enable_o(host_operation_enable_o),
	.token_fifo_advance_o(token_fifo_advance_o),
	.module_interrupt_request_o(module_interrupt_request_o));
